// ===== rtl/port_store_defs.svh
// Constants for the port validation and parameter store block
// =====================================================================
// Functional notes
// - Validation and backup only in manual mode
// - No-check setting: no compare, no backup
// - Legacy revision: check identity, no backup
// - Current revision: master checks vendor/device identity
// - Backup mode, empty store: upload first connect
// - Backup mode: upload on device upload request
// - Backup mode: compare and restore each connect
// - Device access lock blocks any restore
// - Restore mode: upload once, first connect only
// - Restore mode: compare, restore on difference later
// - Restore mode: upload request triggers restore instead
// - Erase store on reset or config change
// - Validation setting defaults to no-check
// - Fastest cycle: device minimum, bounded by master
// - Fixed cycle choices from 1.6 to 120 ms
// - Cycle default fastest, effective in manual only
// - Vendor identifier 16 bits, default zero
// - Device identifier 16 bits, default zero
// - Manual mode exposes the settings; automatic ignores
`ifndef PORT_STORE_DEFS_SVH
`define PORT_STORE_DEFS_SVH

// =====================================================================
// Setting codes and reset values
`define VB_NO_CHECK     3'h0
`define VB_V10          3'h1
`define VB_V11          3'h2
`define VB_V11_BACKUP   3'h3
`define VB_V11_RESTORE  3'h4
`define PORT_MODE_OFF   2'h0
`define PORT_MODE_AUTO  2'h1
`define PORT_MODE_MAN   2'h2
`define CYC_FASTEST     4'h0
`define ID_RESET        16'h0000
// Cycle time unit is 100 us; fixed choices 1.6 .. 120 ms
`define CYC_UNIT_NS     100000
`define CLK_PERIOD_NS   4
`define CYC_TICKS       (`CYC_UNIT_NS / `CLK_PERIOD_NS)
`define MASTER_MIN_CYC  12'h010
// Fixed choices in 100 us units; 120 ms needs 11 bits, so cycle words are 12 bits
`define CYC_1M6         12'h010
`define CYC_3M2         12'h020
`define CYC_4M8         12'h030
`define CYC_8M0         12'h050
`define CYC_20M8        12'h0d0
`define CYC_40M         12'h190
`define CYC_80M         12'h320
`define CYC_120M        12'h4b0
`define DEV_CMD_IDX     16'h0002
`define DEV_CMD_STORE   8'h05
`define DEV_LOCK_IDX    16'h000c

`endif

// ===== rtl/port_store_pkg.sv
// Types for the port validation and parameter store block
package port_store_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CHECK   = 3'b001,
    ST_DECIDE  = 3'b011,
    ST_UPLOAD  = 3'b010,
    ST_RESTORE = 3'b110,
    ST_RUN     = 3'b111,
    ST_FAULT   = 3'b101
  } seq_t;
endpackage

// ===== rtl/cycle_timer.sv
// Port cycle tick generator
`timescale 1ns/1ps
`include "port_store_defs.svh"
module cycle_timer #(
  parameter int TICKS = `CYC_TICKS
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [11:0] units_in,
  // Result
  output logic            tick_out
);
  typedef struct packed {
    logic [31:0] pre;
    logic [11:0] cnt;
    logic        tick;
  } tmr_t;
  tmr_t s_r;
  tmr_t s_nxt;

  // Prescaler to 100 us, then count units; idle when not running
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run_in) begin
      s_nxt.pre = '0;
      s_nxt.cnt = '0;
    end else if (s_r.pre == 32'(TICKS - 1)) begin
      s_nxt.pre = '0;
      if (s_r.cnt + 12'h001 >= units_in) begin
        s_nxt.cnt = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 12'h001;
      end
    end else begin
      s_nxt.pre = s_r.pre + 32'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign tick_out = s_r.tick;
endmodule // cycle_timer

// ===== rtl/port_store.sv
// Per-port identity check, parameter store sequencing and cycle timing
`timescale 1ns/1ps
`include "port_store_defs.svh"
module port_store
  import port_store_pkg::*;
#(
  parameter int TICKS = `CYC_TICKS
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Controller settings
  input  wire logic [1:0]  port_mode_in,
  input  wire logic [2:0]  vb_mode_in,
  input  wire logic [3:0]  cycle_sel_in,
  input  wire logic [15:0] vendor_id_in,
  input  wire logic [15:0] device_id_in,
  input  wire logic        factory_reset_in,
  // Field device status (pin side)
  input  wire logic        dev_connect_in,
  input  wire logic [15:0] dev_vendor_in,
  input  wire logic [15:0] dev_device_in,
  input  wire logic [7:0]  dev_min_cycle_in,
  input  wire logic        upload_request_flag_in,
  input  wire logic        dev_lock_in,
  input  wire logic        params_differ_in,
  // Transfer engine handshake
  input  wire logic        xfer_done_in,
  output logic             upload_out,
  output logic             restore_out,
  // Status
  output logic             store_valid_out,
  output logic             cyclic_en_out,
  output logic             id_fault_out,
  output logic             cycle_tick_out,
  output logic [11:0]      cycle_units_out
);
  // ===================================================================
  // State
  typedef struct packed {
    logic [1:0]  c1, c2;
    logic        u1, u2, l1, l2, d1, d2;
    logic [15:0] v1, v2, i1, i2;
    logic [7:0]  m1, m2;
    seq_t        st;
    logic        store_valid;
    logic        upload;
    logic        restore;
    logic        cyc_en;
    logic        fault;
    logic [1:0]  pm_last;
    logic [2:0]  vb_last;
    logic [1:0]  hold;
    logic [11:0] units;
  } st_t;
  st_t s_r;
  st_t s_nxt;

  logic        manual;
  logic        id_check;
  logic        backup_md;
  logic        restore_md;
  logic        conn;
  logic        id_ok;
  logic [11:0] fixed_units;
  logic        cfg_change;

  // Synchronised device inputs are the second stage only
  assign conn       = s_r.c2[0];
  assign manual     = port_mode_in == `PORT_MODE_MAN;
  assign id_check   = manual && vb_mode_in != `VB_NO_CHECK;
  assign backup_md  = manual && vb_mode_in == `VB_V11_BACKUP;
  assign restore_md = manual && vb_mode_in == `VB_V11_RESTORE;
  assign id_ok      = !id_check || (s_r.v2 == vendor_id_in && s_r.i2 == device_id_in);
  assign cfg_change = port_mode_in != s_r.pm_last || vb_mode_in != s_r.vb_last;

  // Fixed cycle choices in 100 us units
  always_comb begin
    unique case (cycle_sel_in)
      4'h1:    fixed_units = `CYC_1M6;
      4'h2:    fixed_units = `CYC_3M2;
      4'h3:    fixed_units = `CYC_4M8;
      4'h4:    fixed_units = `CYC_8M0;
      4'h5:    fixed_units = `CYC_20M8;
      4'h6:    fixed_units = `CYC_40M;
      4'h7:    fixed_units = `CYC_80M;
      4'h8:    fixed_units = `CYC_120M;
      // Unused codes fall back to the master minimum rather than a zero period
      default: fixed_units = `MASTER_MIN_CYC;
    endcase
  end

  // Sequencer and settings tracking
  always_comb begin
    s_nxt = s_r;
    s_nxt.c1 = {1'b0, dev_connect_in};
    s_nxt.c2 = s_r.c1;
    s_nxt.u1 = upload_request_flag_in;
    s_nxt.u2 = s_r.u1;
    s_nxt.l1 = dev_lock_in;
    s_nxt.l2 = s_r.l1;
    s_nxt.d1 = params_differ_in;
    s_nxt.d2 = s_r.d1;
    s_nxt.v1 = dev_vendor_in;
    s_nxt.v2 = s_r.v1;
    s_nxt.i1 = dev_device_in;
    s_nxt.i2 = s_r.i1;
    s_nxt.m1 = dev_min_cycle_in;
    s_nxt.m2 = s_r.m1;
    s_nxt.pm_last = port_mode_in;
    s_nxt.vb_last = vb_mode_in;
    // Cycle time: fastest is device minimum but never below master minimum
    if (!manual || cycle_sel_in == `CYC_FASTEST) begin
      s_nxt.units = ({4'h0, s_r.m2} > `MASTER_MIN_CYC) ? {4'h0, s_r.m2} : `MASTER_MIN_CYC;
    end else begin
      s_nxt.units = fixed_units;
    end
    // The flag synchroniser still shows the old request just after a transfer;
    // ignoring it briefly avoids a second, needless transfer
    if (s_r.hold != 2'h0) s_nxt.hold = s_r.hold - 2'h1;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.cyc_en = 1'b0;
        s_nxt.fault  = 1'b0;
        if (conn) s_nxt.st = ST_CHECK;
      end
      ST_CHECK: begin
        if (id_ok) s_nxt.st = ST_DECIDE;
        else begin
          s_nxt.fault = 1'b1;
          s_nxt.st = ST_FAULT;
        end
      end
      ST_DECIDE: begin
        if ((backup_md || restore_md) && !s_r.store_valid) begin
          s_nxt.upload = 1'b1;
          s_nxt.st = ST_UPLOAD;
        end else if ((backup_md || restore_md) && s_r.d2 && !s_r.l2) begin
          s_nxt.restore = 1'b1;
          s_nxt.st = ST_RESTORE;
        end else begin
          s_nxt.cyc_en = 1'b1;
          s_nxt.st = ST_RUN;
        end
      end
      ST_UPLOAD: begin
        if (xfer_done_in) begin
          s_nxt.upload = 1'b0;
          s_nxt.hold = 2'h2;
          s_nxt.store_valid = 1'b1;
          s_nxt.cyc_en = 1'b1;
          s_nxt.st = ST_RUN;
        end
      end
      ST_RESTORE: begin
        if (xfer_done_in) begin
          s_nxt.restore = 1'b0;
          s_nxt.hold = 2'h2;
          s_nxt.cyc_en = 1'b1;
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!conn) s_nxt.st = ST_IDLE;
        else if (s_r.u2 && backup_md && s_r.hold == 2'h0) begin
          s_nxt.upload = 1'b1;
          s_nxt.st = ST_UPLOAD;
        end else if (s_r.u2 && restore_md && s_r.store_valid && !s_r.l2 && s_r.hold == 2'h0) begin
          s_nxt.restore = 1'b1;
          s_nxt.st = ST_RESTORE;
        end
      end
      ST_FAULT: begin
        if (!conn) s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Losing the device aborts any transfer in progress
    if (!conn) begin
      s_nxt.upload = 1'b0;
      s_nxt.restore = 1'b0;
      s_nxt.cyc_en = 1'b0;
      if (s_r.st != ST_IDLE) s_nxt.st = ST_IDLE;
    end
    // Erase wins over a completing upload so a stale set is never kept
    if (factory_reset_in || cfg_change) begin
      s_nxt.store_valid = 1'b0;
      s_nxt.upload = 1'b0;
      s_nxt.restore = 1'b0;
      s_nxt.cyc_en = 1'b0;
      s_nxt.st = ST_IDLE;
    end
  end

  // Reset: settings history holds the defaults so no spurious erase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.pm_last <= `PORT_MODE_AUTO;
      s_r.vb_last <= `VB_NO_CHECK;
      s_r.units <= `MASTER_MIN_CYC;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Cycle tick generation while cyclic exchange is enabled
  logic tick;
  cycle_timer #(.TICKS(TICKS)) u_timer (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .run_in   (s_r.cyc_en),
    .units_in (s_r.units),
    .tick_out (tick)
  );

  assign upload_out      = s_r.upload;
  assign restore_out     = s_r.restore;
  assign store_valid_out = s_r.store_valid;
  assign cyclic_en_out   = s_r.cyc_en;
  assign id_fault_out    = s_r.fault;
  assign cycle_tick_out  = tick;
  assign cycle_units_out = s_r.units;

  // ===================================================================
  // Checks
  property p_no_store_unmanaged;
    @(posedge clk_in) disable iff (srst_in)
      (!manual && !s_r.upload) |=> !s_r.upload || manual;
  endproperty
  a_no_store_unmanaged: assert property (p_no_store_unmanaged) else $error("upload outside manual");

  property p_nocheck_no_xfer;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_DECIDE && vb_mode_in == `VB_NO_CHECK) |=> !s_r.upload && !s_r.restore;
  endproperty
  a_nocheck_no_xfer: assert property (p_nocheck_no_xfer) else $error("transfer in no-check");

  property p_v10_no_xfer;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_DECIDE && vb_mode_in == `VB_V10) |=> !s_r.upload && !s_r.restore;
  endproperty
  a_v10_no_xfer: assert property (p_v10_no_xfer) else $error("transfer in legacy mode");

  property p_fault_on_mismatch;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_CHECK && !id_ok && conn && !cfg_change && !factory_reset_in) |=> s_r.fault && !s_r.cyc_en;
  endproperty
  a_fault_on_mismatch: assert property (p_fault_on_mismatch) else $error("mismatch not flagged");

  property p_first_upload;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_DECIDE && backup_md && !s_r.store_valid && conn && !cfg_change && !factory_reset_in)
        |=> s_r.upload;
  endproperty
  a_first_upload: assert property (p_first_upload) else $error("first upload missing");

  property p_lock_blocks;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.l2 && !s_r.restore) |=> !s_r.restore;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("restore despite lock");

  property p_restore_no_reupload;
    @(posedge clk_in) disable iff (srst_in)
      (restore_md && s_r.store_valid && s_r.st == ST_RUN) |=> !s_r.upload;
  endproperty
  a_restore_no_reupload: assert property (p_restore_no_reupload) else $error("upload in restore mode");

  property p_erase;
    @(posedge clk_in) disable iff (srst_in)
      factory_reset_in |=> !s_r.store_valid;
  endproperty
  a_erase: assert property (p_erase) else $error("store not erased");

  property p_fast_bound;
    @(posedge clk_in) disable iff (srst_in)
      (cycle_sel_in == `CYC_FASTEST) |=> s_r.units >= `MASTER_MIN_CYC;
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("cycle below master min");

  property p_flag_upload;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_RUN && conn && s_r.u2 && backup_md && s_r.hold == 2'h0 && !cfg_change && !factory_reset_in)
        |=> s_r.upload;
  endproperty
  a_flag_upload: assert property (p_flag_upload) else $error("upload request ignored");

  property p_fault_no_cyclic;
    @(posedge clk_in) disable iff (srst_in)
      s_r.fault |-> !s_r.cyc_en;
  endproperty
  a_fault_no_cyclic: assert property (p_fault_no_cyclic) else $error("cyclic run with identity fault");

  property p_restore_needs_cause;
    @(posedge clk_in) disable iff (srst_in)
      (!s_r.restore && !s_r.d2 && !s_r.u2) |=> !s_r.restore;
  endproperty
  a_restore_needs_cause: assert property (p_restore_needs_cause) else $error("restore without cause");

  property p_restore_mode_once;
    @(posedge clk_in) disable iff (srst_in)
      (s_r.st == ST_DECIDE && restore_md && s_r.store_valid) |=> !s_r.upload;
  endproperty
  a_restore_mode_once: assert property (p_restore_mode_once) else $error("second upload in restore mode");
endmodule // port_store

// ===== verif/field_dev.sv
// Behavioural field device facing the port store block
`timescale 1ns/1ps
module field_dev #(
  parameter int SLOW = 3
) (
  input  wire logic        clk_in,
  input  wire logic        upload_in,
  input  wire logic        restore_in,
  output logic             connect_out,
  output logic [15:0]      vendor_out,
  output logic [15:0]      device_out,
  output logic [7:0]       min_cycle_out,
  output logic             flag_out,
  output logic             lock_out,
  output logic             differ_out,
  output logic             done_out
);
  logic [15:0] vid_r = 16'h0000;
  logic [15:0] did_r = 16'h0000;
  int          cnt_r = 0;
  // Unplugged lines show the inverse, never the last good identity
  assign vendor_out = connect_out ? vid_r : ~vid_r;
  assign device_out = connect_out ? did_r : ~did_r;
  initial begin
    {connect_out, flag_out, lock_out, differ_out, done_out} = 5'h00;
    min_cycle_out = 8'h00;
  end
  // Plug in with identity, lock and parameter state
  task automatic plug(input logic [15:0] v, input logic [15:0] d, input logic [7:0] mc, input logic lk,
                      input logic df);
    vid_r <= v;
    did_r <= d;
    min_cycle_out <= mc;
    lock_out <= lk;
    differ_out <= df;
    connect_out <= 1'b1;
  endtask
  task automatic unplug();
    connect_out <= 1'b0;
  endtask
  // Only the exact store command raises the upload request
  task automatic sys_cmd(input logic [15:0] idx, input logic [7:0] sub, input logic [7:0] val);
    if (idx === 16'h0002 && sub === 8'h00 && val === 8'h05) flag_out <= 1'b1;
  endtask
  // Transfer answers SLOW+1 cycles into a request; a finished upload clears the flag, a finished restore clears flag and difference
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (upload_in || restore_in) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == SLOW) begin
        done_out <= 1'b1;
        if (upload_in) flag_out <= 1'b0;
        if (restore_in) begin
          differ_out <= 1'b0;
          flag_out <= 1'b0;
        end
      end
    end else cnt_r <= 0;
  end
endmodule // field_dev

// ===== verif/tb_top.sv
// Self-checking bench for the port validation and parameter store block
`timescale 1ns/1ps
`include "port_store_defs.svh"
module tb_top;
  import port_store_pkg::*;
  localparam logic [15:0] VID = 16'h1234; // Arbitrary expected identity
  localparam logic [15:0] DID = 16'h5678; // Arbitrary expected identity
  logic clk_in = 1'b0, srst_in = 1'b1, factory_reset_in = 1'b0;
  logic [1:0]  port_mode_in = `PORT_MODE_OFF;
  logic [2:0]  vb_mode_in = `VB_NO_CHECK;
  logic [3:0]  cycle_sel_in = 4'h0;
  logic [15:0] vendor_id_in = 16'h0000, device_id_in = 16'h0000, dv, dd;
  logic [7:0]  dmc;
  logic [11:0] cycle_units_out;
  logic dc, df_r, dl, ddf, dn, upload_out, restore_out, store_valid_out, cyclic_en_out, id_fault_out;
  logic cycle_tick_out, saw_up, saw_rs;
  int miscompares = 0, samples_checked = 0, cyc = 0, ticks;
  // ==================================================================
  // Clock, design and far-side model
  initial forever #2 clk_in = ~clk_in;
  port_store #(.TICKS(4)) port_store_i (.clk_in(clk_in), .srst_in(srst_in), .port_mode_in(port_mode_in),
    .vb_mode_in(vb_mode_in), .cycle_sel_in(cycle_sel_in), .vendor_id_in(vendor_id_in), .device_id_in(device_id_in),
    .factory_reset_in(factory_reset_in), .dev_connect_in(dc), .dev_vendor_in(dv), .dev_device_in(dd),
    .dev_min_cycle_in(dmc), .upload_request_flag_in(df_r), .dev_lock_in(dl), .params_differ_in(ddf),
    .xfer_done_in(dn), .upload_out(upload_out), .restore_out(restore_out), .store_valid_out(store_valid_out),
    .cyclic_en_out(cyclic_en_out), .id_fault_out(id_fault_out), .cycle_tick_out(cycle_tick_out),
    .cycle_units_out(cycle_units_out));
  field_dev field_dev_i (.clk_in(clk_in), .upload_in(upload_out), .restore_in(restore_out), .connect_out(dc),
    .vendor_out(dv), .device_out(dd), .min_cycle_out(dmc), .flag_out(df_r), .lock_out(dl), .differ_out(ddf),
    .done_out(dn));
  // ==================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [1:0] pm, input logic [2:0] vb, input logic [3:0] cs);
    @(posedge clk_in);
    port_mode_in <= pm;
    vb_mode_in <= vb;
    cycle_sel_in <= cs;
    vendor_id_in <= VID;
    device_id_in <= DID;
  endtask
  // Watch a bounded window and remember any transfer request seen
  task automatic watch(input int n);
    saw_up = 1'b0;
    saw_rs = 1'b0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      saw_up |= upload_out;
      saw_rs |= restore_out;
    end
  endtask
  task automatic plug(input logic [15:0] v, input logic [7:0] mc, input logic lk, input logic df);
    @(posedge clk_in);
    field_dev_i.plug(v, DID, mc, lk, df);
    watch(24);
  endtask
  task automatic unplug();
    @(posedge clk_in);
    field_dev_i.unplug();
    watch(8);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==================================================================
  // Scenarios
  task automatic t_ids();
    cfg(`PORT_MODE_MAN, `VB_NO_CHECK, 4'h0);
    plug(16'h0bad, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs, id_fault_out}, 16'h0000);
    unplug();
    cfg(`PORT_MODE_MAN, `VB_V10, 4'h0);
    plug(16'h0bad, 8'h08, 1'b0, 1'b0);
    chk({id_fault_out, cyclic_en_out}, 16'h0002);
    unplug();
    plug(VID, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs, id_fault_out, cyclic_en_out}, 16'h0001);
    unplug();
    cfg(`PORT_MODE_MAN, `VB_V11, 4'h0);
    @(posedge clk_in);
    field_dev_i.plug(VID, 16'h0bad, 8'h08, 1'b0, 1'b1);
    watch(24);
    chk({saw_up, saw_rs, id_fault_out, cyclic_en_out}, 16'h0002);
    unplug();
    plug(VID, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs, id_fault_out, cyclic_en_out}, 16'h0001);
    unplug();
    $display("test ids done");
  endtask
  task automatic t_backup();
    cfg(`PORT_MODE_MAN, `VB_V11_BACKUP, 4'h0);
    plug(VID, 8'h08, 1'b0, 1'b0);
    chk({saw_up, saw_rs, store_valid_out}, 16'h0005);
    @(posedge clk_in);
    field_dev_i.sys_cmd(16'h0002, 8'h00, 8'h05);
    watch(24);
    chk({saw_up, saw_rs}, 16'h0002);
    unplug();
    plug(VID, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs}, 16'h0001);
    unplug();
    plug(VID, 8'h08, 1'b1, 1'b1);
    chk({saw_up, saw_rs}, 16'h0000);
    unplug();
    $display("test backup done");
  endtask
  task automatic t_restore();
    cfg(`PORT_MODE_MAN, `VB_V11_RESTORE, 4'h0);
    watch(4);
    chk(store_valid_out, 16'h0000);
    plug(VID, 8'h08, 1'b0, 1'b0);
    chk({saw_up, store_valid_out}, 16'h0003);
    unplug();
    plug(VID, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs}, 16'h0001);
    @(posedge clk_in);
    field_dev_i.sys_cmd(16'h0002, 8'h00, 8'h05);
    watch(24);
    chk({saw_up, saw_rs}, 16'h0001);
    @(posedge clk_in);
    factory_reset_in <= 1'b1;
    @(posedge clk_in);
    factory_reset_in <= 1'b0;
    watch(4);
    chk(store_valid_out, 16'h0000);
    unplug();
    cfg(`PORT_MODE_AUTO, `VB_V11_BACKUP, 4'h0);
    plug(VID, 8'h08, 1'b0, 1'b1);
    chk({saw_up, saw_rs}, 16'h0000);
    unplug();
    $display("test restore done");
  endtask
  task automatic t_cycle();
    logic [11:0] exp [1:8];
    exp = '{12'h010, 12'h020, 12'h030, 12'h050, 12'h0d0, 12'h190, 12'h320, 12'h4b0};
    for (int s = 1; s <= 8; s++) begin
      cfg(`PORT_MODE_MAN, `VB_NO_CHECK, s[3:0]);
      watch(3);
      chk(cycle_units_out, exp[s]);
    end
    cfg(`PORT_MODE_MAN, `VB_NO_CHECK, 4'h0);
    plug(VID, 8'h30, 1'b0, 1'b0);
    chk(cycle_units_out, 16'h0030);
    unplug();
    plug(VID, 8'h08, 1'b0, 1'b0);
    chk(cycle_units_out, 16'h0010);
    ticks = 0;
    repeat (128) begin
      @(posedge clk_in);
      #1;
      ticks += cycle_tick_out;
    end
    chk(ticks[15:0], 16'h0002);
    unplug();
    $display("test cycle done");
  endtask
  // ==================================================================
  // Main sequence and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    watch(2);
    chk({upload_out, restore_out, store_valid_out, cyclic_en_out, cycle_units_out}, 16'h0010);
    t_ids();
    t_backup();
    t_restore();
    t_cycle();
    give_verdict();
  end
endmodule // tb_top
